// ### logic/tpc_map.svh
// register offsets, field positions and fixed widths of the pcs block
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_PAT 8'h04
`define TPC_OFF_STAT 8'h08
`define TPC_CTRL_RST 32'h0000_0002
`define TPC_CTRL_MASK 32'h0000_037F
`define TPC_PAT_RST 20'h000FF
`define TPC_B_LOWLAT 0
`define TPC_B_ENC 1
`define TPC_B_DW 2
`define TPC_B_BSER 3
`define TPC_B_DET 4
`define TPC_B_TXREG 5
`define TPC_B_SWAP 6
`define TPC_F_PLEN 9:8
`define TPC_PLEN_16 2'h1
`define TPC_PLEN_20 2'h2
`define TPC_PLEN_32 2'h3
`define TPC_S_SLIP 4:0
`define TPC_S_LOCK 8
`define TPC_S_ORD 9
`define TPC_S_CERR 10
`define TPC_S_OVF 11
`define TPC_S_TXSLIP 20:16
`define TPC_W8 5'h08
`define TPC_W10 5'h0A
`define TPC_W16 5'h10
`define TPC_W20 5'h14
`define TPC_PMA_BITS 20
`define TPC_ONES 20'hFFFFF
`define TPC_SLIP_DW 5'h13
`endif

// ### logic/tpc_pkg.sv
// shared types of the pcs block
`default_nettype none
package tpc_pkg;
   typedef logic [19:0] tpc_pma_t;
   typedef logic [39:0] tpc_wide_t;
   typedef logic [4:0] tpc_slip_t;
   typedef enum logic [1:0] {
      tpc_search = 2'b01,
      tpc_locked = 2'b10
   } tpc_align_t;
endpackage : tpc_pkg
`default_nettype wire

// ### logic/tpc_fifo_if.sv
// handshake bundle between the datapath and a phase compensation fifo
`default_nettype none
interface tpc_fifo_if #(parameter int W = 40);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic reg_mode;
   modport fifo (input in_valid, in_data, out_ready, reg_mode,
      output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, reg_mode,
      input in_ready, out_valid, out_data);
endinterface : tpc_fifo_if
`default_nettype wire

// ### logic/tpc_fifo.sv
// phase compensation fifo with a single-register mode
`default_nettype none
module tpc_fifo #(
   parameter int W = 40,
   parameter int DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   tpc_fifo_if.fifo q
);
   import tpc_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } tpc_fifo_st_t;
   tpc_fifo_st_t st_ff;
   tpc_fifo_st_t nxt_st;
   logic push;
   logic pop;
   logic [AW:0] cap;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least two");
   end

   assign q.in_ready = st_ff.rdy;
   assign q.out_valid = (st_ff.cnt != '0);
   assign q.out_data = st_ff.mem[st_ff.rp];

   always_comb begin
      nxt_st = st_ff;
      push = q.in_valid && st_ff.rdy;
      pop = q.out_ready && (st_ff.cnt != '0);
      // register mode caps the fill at one word, two if the reader stalls right after a pop
      cap = q.reg_mode ? (AW + 1)'(1) : (AW + 1)'(DEPTH); // see R11
      if (push) begin
         nxt_st.mem[st_ff.wp] = q.in_data;
         nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      // register mode takes a word while the held one leaves: a steady stream
      // keeps one word of latency, a reader that stalls lets in one more
      nxt_st.rdy = (nxt_st.cnt < cap) || (q.reg_mode && q.out_ready && nxt_st.cnt == cap);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : tpc_fifo
`default_nettype wire

// ### logic/tpc_top.sv
// pcs datapath for basic and deterministic latency modes with apb control
`default_nettype none
`include "tpc_map.svh"
// Behaviour
// [R01] single width pma word is 8 bits raw, 10 bits with 8b10b coding
// [R02] byte serializer optional; both phase compensation fifos always in path
// [R03] word aligner active in regular basic mode, bypassed in low latency
// [R04] low latency skips coding, aligner, deskew, rate match and byte ordering
// [R05] 16-bit double width: byte ordering only with 16 or 32 bit pattern
// [R06] 20-bit double width: byte ordering only with 20 bit pattern
// [R07] configuring party enables byte serializer above 1.92G line rate
// [R08] deterministic latency supports 16 and 20 bit pma words
// [R09] deterministic latency enables tx bit slip, forces rx fifo register mode
// [R10] 5-bit rx slip count output and 5-bit tx slip amount input
// [R11] fifo in register mode acts as one pipeline register; code takes a second word if the reader stalls right after a pop
// [R12] tx fifo register mode optional in deterministic latency, off by default
// [R13] pll feedback needs reference clock equal to parallel clock
// [R14] 8 or 10 bit width: slip count equals bits slipped
// [R15] 16 or 20 bit width: slip count equals 19 minus bits slipped
// [R16] aligner slips 0 to 9 bits single width, 0 to 19 double; code stops at 7 and 15 at 8 and 16 bit widths
// [R17] surrounding logic loops rx slip count back to tx slip amount
// [R18] deterministic latency coding present but may be disabled
// [R19] tx bit slip delays the word by the slip amount, held until change
module tpc_top #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tpc_pkg::tpc_wide_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output tpc_pkg::tpc_pma_t tx_pma_data,
   input wire logic tx_pma_ready,
   input wire tpc_pkg::tpc_slip_t tx_slip_amount,
   input wire tpc_pkg::tpc_pma_t rx_pma_data,
   output tpc_pkg::tpc_wide_t rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output tpc_pkg::tpc_slip_t rx_slip_count
);
   import tpc_pkg::*;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [19:0] pat;
      tpc_align_t al;
      logic [4:0] slip;
      logic [19:0] rx_prev;
      logic [19:0] tx_prev;
      logic [19:0] rx_lo;
      logic rx_phase;
      logic tx_phase;
      logic cerr;
      logic ovf;
      logic [19:0] txd;
      logic [4:0] slipcnt;
      logic rxo_v;
      logic [39:0] rxo_d;
      logic [31:0] rdata;
      logic rdy;
      logic slverr;
   } tpc_top_st_t;

   localparam tpc_top_st_t ST_RST = '{ctrl: `TPC_CTRL_RST, pat: `TPC_PAT_RST,
      al: tpc_search, default: '0};

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("fifo depth below two cannot hold a serializer pair");
   end

   function automatic logic [9:0] tpc_enc8(input logic [7:0] b);
      return {~(^b), ^b, b};
   endfunction : tpc_enc8

   function automatic logic tpc_chk10(input logic [9:0] g);
      return g[9:8] == {~(^g[7:0]), ^g[7:0]};
   endfunction : tpc_chk10

   tpc_top_st_t st_ff;
   tpc_top_st_t nxt_st;
   logic lowlat, enc, dw, det, bser, ord, hit, word_ok, cerr, rx_push, wr, clr;
   logic [1:0] plen;
   logic [4:0] wid, tx_shift, hit_pos;
   logic [19:0] mask, half, tx_word, tx_out, rx_cur, aligned, dec_raw, dec;
   logic [39:0] tx_comb, rx_comb, rx_in;
   logic [31:0] rd;

   tpc_fifo_if #(.W(40)) txq ();
   tpc_fifo_if #(.W(40)) rxq ();

   // ------------------------------------------------------------
   // phase compensation fifos
   // ------------------------------------------------------------
   tpc_fifo #(.W(40), .DEPTH(FIFO_DEPTH)) u_txq (
      .pclk(pclk),
      .presetn(presetn),
      .q(txq.fifo)
   );
   tpc_fifo #(.W(40), .DEPTH(FIFO_DEPTH)) u_rxq (
      .pclk(pclk),
      .presetn(presetn),
      .q(rxq.fifo)
   );

   assign txq.in_valid = tx_valid;
   assign txq.in_data = tx_data;
   assign txq.out_ready = tx_pma_ready && (!bser || st_ff.tx_phase); // see R02
   assign txq.reg_mode = det && st_ff.ctrl[`TPC_B_TXREG]; // see R12
   assign rxq.in_valid = rx_push;
   assign rxq.in_data = rx_in;
   assign rxq.out_ready = !st_ff.rxo_v || rx_ready;
   assign rxq.reg_mode = det; // see R09

   assign tx_ready = txq.in_ready;
   assign tx_pma_data = st_ff.txd;
   assign rx_data = st_ff.rxo_d;
   assign rx_valid = st_ff.rxo_v;
   assign rx_slip_count = st_ff.slipcnt;
   assign prdata = st_ff.rdata;
   assign pready = st_ff.rdy;
   assign pslverr = st_ff.slverr;

   always_comb begin
      nxt_st = st_ff;
      // ------------------------------------------------------------
      // mode decode
      // ------------------------------------------------------------
      lowlat = st_ff.ctrl[`TPC_B_LOWLAT];
      enc = st_ff.ctrl[`TPC_B_ENC] && !lowlat; // see R04 R18
      dw = st_ff.ctrl[`TPC_B_DW];
      det = st_ff.ctrl[`TPC_B_DET];
      bser = st_ff.ctrl[`TPC_B_BSER];
      plen = st_ff.ctrl[`TPC_F_PLEN];
      wid = dw ? (enc ? `TPC_W20 : `TPC_W16) : (enc ? `TPC_W10 : `TPC_W8); // see R01 R08
      mask = `TPC_ONES >> (`TPC_W20 - wid);

      // ------------------------------------------------------------
      // transmit: serializer, encoder, bit slip
      // ------------------------------------------------------------
      tx_shift = '0;
      if (det) begin
         // amount clamped below the word width, else the window runs off
         tx_shift = (tx_slip_amount < wid) ? tx_slip_amount : wid - 5'h01; // see R09 R10
      end
      half = (bser && st_ff.tx_phase) ? txq.out_data[39:20] : txq.out_data[19:0];
      tx_word = half & mask;
      if (enc) begin
         tx_word = dw ? {tpc_enc8(half[15:8]), tpc_enc8(half[7:0])}
                      : {10'h000, tpc_enc8(half[7:0])};
      end
      if (!txq.out_valid) begin
         tx_word = '0;
      end
      tx_comb = ({20'h00000, tx_word} << wid) | {20'h00000, st_ff.tx_prev};
      tx_out = 20'(tx_comb >> (wid - tx_shift)) & mask; // see R19
      if (tx_pma_ready) begin
         nxt_st.tx_prev = tx_word;
         nxt_st.txd = tx_out;
         if (bser && txq.out_valid) begin
            nxt_st.tx_phase = !st_ff.tx_phase;
         end
      end
      if (!bser) begin
         nxt_st.tx_phase = 1'b0;
      end

      // ------------------------------------------------------------
      // receive: word aligner
      // ------------------------------------------------------------
      rx_cur = rx_pma_data & mask;
      rx_comb = ({20'h00000, rx_cur} << wid) | {20'h00000, st_ff.rx_prev};
      hit = 1'b0;
      hit_pos = '0;
      for (int s = 0; s < `TPC_PMA_BITS; s++) begin
         // offsets stop one short of the width: 0..7, 0..9, 0..15 or 0..19
         if (!hit && 5'(s) < wid && (20'(rx_comb >> s) & mask) == (st_ff.pat & mask)) begin
            hit = 1'b1; // see R16
            hit_pos = 5'(s);
         end
      end
      nxt_st.rx_prev = rx_cur;
      if (lowlat) begin
         nxt_st.al = tpc_search; // see R03 R04
         nxt_st.slip = '0;
      end else if (st_ff.al == tpc_search && hit) begin
         nxt_st.al = tpc_locked; // see R03
         nxt_st.slip = hit_pos;
      end
      aligned = 20'(rx_comb >> st_ff.slip) & mask;
      word_ok = lowlat || st_ff.al == tpc_locked;
      // count reported so that the far end can cancel it on transmit
      nxt_st.slipcnt = dw ? `TPC_SLIP_DW - st_ff.slip : st_ff.slip; // see R14 R15

      // ------------------------------------------------------------
      // receive: decoder, byte ordering, deserializer
      // ------------------------------------------------------------
      dec_raw = aligned;
      cerr = 1'b0;
      if (enc) begin
         dec_raw = dw ? {4'h0, aligned[17:10], aligned[7:0]} : {12'h000, aligned[7:0]};
         cerr = !tpc_chk10(aligned[9:0]) || (dw && !tpc_chk10(aligned[19:10])); // see R18
      end
      ord = dw && !lowlat && (enc ? plen == `TPC_PLEN_20
                                  : (plen == `TPC_PLEN_16 || plen == `TPC_PLEN_32)); // see R05 R06
      dec = dec_raw;
      if (ord && st_ff.ctrl[`TPC_B_SWAP]) begin
         dec = {dec_raw[19:16], dec_raw[7:0], dec_raw[15:8]};
      end
      rx_push = word_ok && (!bser || st_ff.rx_phase); // see R02
      rx_in = bser ? {dec, st_ff.rx_lo} : {20'h00000, dec};
      if (word_ok && bser) begin
         nxt_st.rx_phase = !st_ff.rx_phase;
         if (!st_ff.rx_phase) begin
            nxt_st.rx_lo = dec;
         end
      end
      if (!bser) begin
         nxt_st.rx_phase = 1'b0;
      end
      // output stage keeps rx_data straight from a flop
      if (rxq.out_valid && rxq.out_ready) begin
         nxt_st.rxo_v = 1'b1;
         nxt_st.rxo_d = rxq.out_data;
      end else if (rx_ready) begin
         nxt_st.rxo_v = 1'b0;
      end

      // ------------------------------------------------------------
      // apb slave
      // ------------------------------------------------------------
      wr = psel && penable && pwrite && st_ff.rdy && !st_ff.slverr;
      clr = wr && paddr == `TPC_OFF_STAT;
      // a new event wins over a clear in the same cycle
      nxt_st.cerr = (st_ff.cerr && !(clr && pwdata[`TPC_S_CERR])) || (word_ok && cerr);
      nxt_st.ovf = (st_ff.ovf && !(clr && pwdata[`TPC_S_OVF])) || (rx_push && !rxq.in_ready);
      if (wr && paddr == `TPC_OFF_CTRL) begin
         nxt_st.ctrl = pwdata & `TPC_CTRL_MASK;
         nxt_st.al = tpc_search;
         nxt_st.slip = '0;
      end
      if (wr && paddr == `TPC_OFF_PAT) begin
         nxt_st.pat = pwdata[19:0];
         nxt_st.al = tpc_search;
         nxt_st.slip = '0;
      end
      rd = '0;
      case (paddr)
         `TPC_OFF_CTRL: begin
            rd = st_ff.ctrl;
         end
         `TPC_OFF_PAT: begin
            rd[19:0] = st_ff.pat;
         end
         `TPC_OFF_STAT: begin
            rd[`TPC_S_SLIP] = st_ff.slipcnt;
            rd[`TPC_S_LOCK] = (st_ff.al == tpc_locked);
            rd[`TPC_S_ORD] = ord;
            rd[`TPC_S_CERR] = st_ff.cerr;
            rd[`TPC_S_OVF] = st_ff.ovf;
            rd[`TPC_S_TXSLIP] = tx_slip_amount;
         end
         default: begin
            rd = '0;
         end
      endcase
      // answer is prepared in setup so the access phase needs no wait
      nxt_st.rdy = psel && !penable;
      nxt_st.rdata = (psel && !penable && !pwrite) ? rd : '0;
      nxt_st.slverr = psel && !penable && !(paddr == `TPC_OFF_CTRL
         || paddr == `TPC_OFF_PAT || paddr == `TPC_OFF_STAT);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_tx_raw_narrow: assert property ( // see R01
      (tx_pma_ready && !dw && !enc) |=> (tx_pma_data[19:8] == '0))
      else $error("raw single width word spills above bit 7");

   a_tx_coded_narrow: assert property ( // see R01
      (tx_pma_ready && !dw && enc) |=> (tx_pma_data[19:10] == '0))
      else $error("coded single width word spills above bit 9");

   a_lowlat_bypass: assert property ( // see R04
      lowlat |=> (st_ff.slip == '0 && st_ff.al == tpc_search))
      else $error("aligner still slipping in low latency mode");

   a_order_gate: assert property ( // see R05 R06
      (rx_push && !ord && !bser) |-> (rxq.in_data[15:0] == dec_raw[15:0]))
      else $error("byte order changed while ordering unavailable");

   a_rx_regmode: assert property ( // see R09 R11
      (det && $past(det) && rxq.out_valid && !$past(rxq.out_ready)) |-> !rxq.in_ready)
      else $error("rx register takes a word while the held word is stalled");

   a_tx_regmode: assert property ( // see R12
      (txq.reg_mode && $past(txq.reg_mode) && txq.out_valid && !$past(txq.out_ready))
         |-> !txq.in_ready)
      else $error("tx register takes a word while the held word is stalled");

   a_no_slip_off: assert property ( // see R09
      (tx_pma_ready && !det) |=> (tx_pma_data == $past(tx_word)))
      else $error("tx word delayed outside deterministic latency mode");

   a_cnt_single: assert property ( // see R14
      !dw |=> (rx_slip_count == $past(st_ff.slip)))
      else $error("single width slip count differs from bits slipped");

   a_cnt_double: assert property ( // see R15
      dw |=> (rx_slip_count == `TPC_SLIP_DW - $past(st_ff.slip)))
      else $error("double width slip count not 19 minus bits slipped");

   a_slip_range: assert property ( // see R16
      $stable(st_ff.ctrl) |-> (st_ff.slip < wid))
      else $error("aligner slip beyond the word width");

   a_dec_off: assert property ( // see R18
      !enc |=> !(st_ff.cerr && !$past(st_ff.cerr)))
      else $error("code error raised with the decoder disabled");
endmodule : tpc_top
`default_nettype wire

// ### test/tpc_far_model.sv
// far side model: pma stall, receive bit stream and fabric slip loop
`default_nettype none
module tpc_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] width,
   input wire logic [4:0] offset,
   input wire logic [19:0] pat,
   input wire logic stall,
   input wire logic loop_back,
   input wire tpc_pkg::tpc_slip_t slip_set,
   input wire tpc_pkg::tpc_slip_t rx_slip_count,
   output tpc_pkg::tpc_pma_t rx_pma_data,
   output logic tx_pma_ready,
   output tpc_pkg::tpc_slip_t tx_slip_amount
);
   import tpc_pkg::*;
   // pattern rotated by the offset, so every word pair holds it at that bit
   function automatic tpc_pma_t rot(input logic [19:0] p, input int w, input int o);
      tpc_pma_t r;
      r = '0;
      for (int i = 0; i < w; i++) begin
         r[(i + o) % w] = p[i];
      end
      return r;
   endfunction : rot
   // reference of the clock_multiplier_pll is pclk itself, same rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_pma_data <= '0;
         tx_pma_ready <= 1'b0;
         tx_slip_amount <= '0;
      end else begin
         rx_pma_data <= rot(pat, int'(width), int'(offset));
         tx_pma_ready <= !stall;
         // fabric wiring of the rx slip count into the tx slip amount
         tx_slip_amount <= loop_back ? rx_slip_count : slip_set;
      end
   end
endmodule : tpc_far_model
`default_nettype wire

// ### test/tpc_top_bench.sv
// self-checking bench of the pcs datapath
`default_nettype none
`include "tpc_map.svh"
module tpc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   tpc_wide_t tx_data, rx_data;
   tpc_pma_t tx_pma_data, rx_pma_data;
   tpc_slip_t tx_slip_amount, rx_slip_count, slip_set;
   logic tx_valid, tx_ready, tx_pma_ready, rx_valid, rx_ready, stall, loop_back;
   logic [4:0] width, offset;
   logic [19:0] pat;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   tpc_top #(.FIFO_DEPTH(16)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_pma_data(tx_pma_data), .tx_pma_ready(tx_pma_ready),
      .tx_slip_amount(tx_slip_amount), .rx_pma_data(rx_pma_data), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_slip_count(rx_slip_count));
   tpc_far_model u_far (.pclk(pclk), .presetn(presetn), .width(width), .offset(offset),
      .pat(pat), .stall(stall), .loop_back(loop_back), .slip_set(slip_set),
      .rx_slip_count(rx_slip_count), .rx_pma_data(rx_pma_data),
      .tx_pma_ready(tx_pma_ready), .tx_slip_amount(tx_slip_amount));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // one edge first, so psel is never lowered and raised in one time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, `TPC_OFF_CTRL, '0);
      chk("ctrl reset", 40'(rd), 40'(`TPC_CTRL_RST));
      apb(1'b0, `TPC_OFF_PAT, '0);
      chk("pat reset", 40'(rd), 40'h000FF);
      apb(1'b1, `TPC_OFF_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, `TPC_OFF_CTRL, '0);
      chk("ctrl mask", 40'(rd), 40'h37F);
      apb(1'b1, 8'h0C, 32'h1);
      chk("unmapped err", 40'(err), 40'h1);
      $display("test regs done");
   endtask : t_regs
   task automatic t_tx_width;
      logic [11:0] mode [5] = '{12'h001, 12'h000, 12'h005, 12'h004, 12'h00C};
      tpc_pma_t keep [4] = '{20'h000FF, 20'h000FF, 20'h0FFFF, 20'h0FFFF};
      tpc_pma_t a;
      for (int i = 0; i < 5; i++) begin
         tx_data <= (i == 4) ? 40'h0ABCD_01234 : 40'hA5C3E_96B7D;
         apb(1'b1, `TPC_OFF_CTRL, 32'(mode[i]));
         tx_valid <= 1'b1;
         cyc(8);
         a = tx_pma_data;
         cyc(1);
         if (i < 4) chk("tx width", 40'(a), 40'(20'h96B7D & keep[i]));
         else chk("byte ser", 40'(a ^ tx_pma_data), 40'h0B9F9);
         tx_valid <= 1'b0;
         cyc(4);
      end
      $display("test tx width done");
   endtask : t_tx_width
   task automatic t_tx_slip;
      int n [5] = '{0, 3, 15, 17, 3};
      int e;
      tx_data <= 40'h000F1;
      apb(1'b1, `TPC_OFF_CTRL, 32'h014);
      tx_valid <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (i == 4) apb(1'b1, `TPC_OFF_CTRL, 32'h004);
         slip_set <= 5'(n[i]);
         cyc(8);
         e = (i == 4) ? 0 : ((n[i] > 15) ? 15 : n[i]);
         chk("tx slip", 40'(tx_pma_data), 40'(16'({2{16'h00F1}} >> (16 - e))));
      end
      tx_valid <= 1'b0;
      slip_set <= '0;
      $display("test tx slip done");
   endtask : t_tx_slip
   task automatic t_fifo;
      int cap [2] = '{16, 1};
      int n, k;
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `TPC_OFF_CTRL, m ? 32'h034 : 32'h014);
         stall <= 1'b1;
         cyc(4);
         n = 0;
         tx_data <= 40'h1;
         tx_valid <= 1'b1;
         repeat (40) begin
            @(posedge pclk);
            if (tx_ready === 1'b1) begin
               n++;
               tx_data <= 40'(n + 1);
            end
         end
         tx_valid <= 1'b0;
         chk("tx fill", 40'(n), 40'(cap[m]));
         stall <= 1'b0;
         k = 0;
         repeat (40) begin
            @(posedge pclk);
            if (tx_pma_data !== '0) begin
               k++;
               chk("tx drain", 40'(tx_pma_data), 40'(k));
            end
         end
         chk("tx drained", 40'(k), 40'(n));
      end
      $display("test fifo done");
   endtask : t_fifo
   task automatic t_rx_scan;
      int e;
      for (int m = 0; m < 2; m++) begin
         width <= m ? `TPC_W20 : `TPC_W10;
         pat <= m ? 20'h003FF : 20'h0001F;
         loop_back <= m[0];
         apb(1'b1, `TPC_OFF_CTRL, m ? 32'h016 : 32'h012);
         for (int s = 0; s < (m ? 20 : 10); s++) begin
            offset <= 5'(s);
            cyc(3);
            apb(1'b1, `TPC_OFF_PAT, m ? 32'h3FF : 32'h01F);
            cyc(8);
            e = m ? 19 - s : s;
            chk("rx slip", 40'(rx_slip_count), 40'(e));
            apb(1'b0, `TPC_OFF_STAT, '0);
            chk("rx lock", 40'(rd[`TPC_S_LOCK]), 40'h1);
            chk("code err", 40'(rd[`TPC_S_CERR]), 40'h1);
            if (m) chk("slip loop", 40'(rd[`TPC_S_TXSLIP]), 40'(e));
         end
      end
      loop_back <= 1'b0;
      $display("test rx scan done");
   endtask : t_rx_scan
   task automatic t_rx_path;
      width <= `TPC_W16;
      pat <= 20'h000FF;
      offset <= 5'h05;
      apb(1'b1, `TPC_OFF_PAT, 32'h0FF);
      apb(1'b1, `TPC_OFF_CTRL, 32'h014);
      cyc(10);
      chk("rx aligned", 40'(rx_data[15:0]), 40'h00FF);
      chk("rx valid", 40'(rx_valid), 40'h1);
      apb(1'b1, `TPC_OFF_CTRL, 32'h154);
      cyc(10);
      chk("rx swap", 40'(rx_data[15:0]), 40'hFF00);
      apb(1'b1, `TPC_OFF_CTRL, 32'h00C);
      cyc(10);
      chk("rx deser", rx_data, 40'h000FF_000FF);
      apb(1'b1, `TPC_OFF_CTRL, 32'h005);
      cyc(10);
      chk("rx raw", 40'(rx_data[15:0]), 40'h1FE0);
      // one-word register stage overflows almost at once when stalled
      rx_ready <= 1'b0;
      apb(1'b1, `TPC_OFF_CTRL, 32'h014);
      apb(1'b1, `TPC_OFF_STAT, 32'hC00);
      cyc(4);
      apb(1'b0, `TPC_OFF_STAT, '0);
      chk("reg ovf", 40'(rd[`TPC_S_OVF]), 40'h1);
      apb(1'b1, `TPC_OFF_CTRL, 32'h004);
      apb(1'b1, `TPC_OFF_STAT, 32'hC00);
      apb(1'b0, `TPC_OFF_STAT, '0);
      chk("deep no ovf", 40'(rd[`TPC_S_OVF]), 40'h0);
      cyc(30);
      apb(1'b0, `TPC_OFF_STAT, '0);
      chk("deep ovf", 40'(rd[`TPC_S_OVF]), 40'h1);
      rx_ready <= 1'b1;
      $display("test rx path done");
   endtask : t_rx_path
   task automatic t_order;
      logic [11:0] mode [6] = '{12'h104, 12'h304, 12'h204, 12'h206, 12'h106, 12'h105};
      logic want [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `TPC_OFF_CTRL, 32'(mode[i]));
         apb(1'b0, `TPC_OFF_STAT, '0);
         chk("order avail", 40'(rd[`TPC_S_ORD]), 40'(want[i]));
      end
      $display("test order done");
   endtask : t_order
   // ------------------------------------------------------------
   // clock, timeout and main sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, tx_valid, stall, loop_back} = '0;
      paddr = '0;
      pwdata = '0;
      tx_data = '0;
      rx_ready = 1'b1;
      slip_set = '0;
      width = '0;
      offset = '0;
      pat = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_tx_width();
      t_tx_slip();
      t_fifo();
      t_rx_scan();
      t_rx_path();
      t_order();
      close_out();
   end
endmodule : tpc_top_bench
`default_nettype wire
